// *** core_timer_pkg.sv ***
package core_timer_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [12:0] IDX_CONTROL_STATUS = 13'h0008;
  localparam logic [12:0] IDX_CHAIN_COUNT    = 13'h0009;
  localparam logic [12:0] IDX_WATCHDOG_CLEAR = 13'h1ff0;
  localparam int          ADDR_BITS          = 13;
  localparam int          DATA_BITS          = 32;

  // Control/status and watchdog clear field positions.
  localparam int BIT_OVERFLOW_FLAG       = 7;
  localparam int BIT_PERIODIC_FLAG       = 6;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 5;
  localparam int BIT_PERIODIC_IRQ_ENABLE = 4;
  localparam int BIT_OVERFLOW_FLAG_CLEAR = 3;
  localparam int BIT_PERIODIC_FLAG_CLEAR = 2;
  localparam int BIT_RATE_SEL_HI         = 1;
  localparam int BIT_RATE_SEL_LO         = 0;
  localparam int BIT_WATCHDOG_CLEAR      = 0;

  // Values after reset.
  localparam logic [1:0] RATE_SEL_RESET = 2'h3;

  // Chain layout: prescaler, readable counter, four stages, three periodic stages.
  localparam int CHAIN_BITS     = 17;
  localparam int PRESCALE_BITS  = 2;
  localparam int COUNT_BITS     = 8;
  localparam int OVERFLOW_TAP   = 9;
  localparam int PERIODIC_TAP   = 13;
  localparam int WATCHDOG_BITS  = 3;

  // Power-on delay in bus clock cycles, counted on the low chain stages.
  localparam int           POR_BITS   = 12;
  localparam logic [11:0]  POR_CYCLES = 12'hfe0;

  typedef enum logic [1:0] {
    POWER_ON_DELAY,
    RUNNING
  } reset_state_type;

endpackage : core_timer_pkg

// *** chain_if.sv ***
`timescale 1ns/10ps
interface chain_if;
  import core_timer_pkg::*;

  logic                  chain_clear;
  logic [CHAIN_BITS-1:0] count;
  logic                  overflow_evt;
  logic [1:0]            rate_sel;
  logic                  wdog_clear;
  logic                  periodic_evt;
  logic                  wdog_timeout;

  modport divider (
    input  chain_clear,
    output count,
    output overflow_evt
  );

  modport watchdog (
    input  chain_clear,
    input  count,
    input  rate_sel,
    input  wdog_clear,
    output periodic_evt,
    output wdog_timeout
  );

  modport control (
    output chain_clear,
    input  count,
    input  overflow_evt,
    output rate_sel,
    output wdog_clear,
    input  periodic_evt,
    input  wdog_timeout
  );
endinterface : chain_if

// *** core_divider.sv ***
`timescale 1ns/10ps
module core_divider (
  input wire logic CLK,
  input wire logic RSTN,
  chain_if.divider chain
);
  import core_timer_pkg::*;

  logic [CHAIN_BITS-1:0] count;

  // synchronous chain
  // Every stage advances on the common clock; a stage moves only when all
  // lower stages are at one, which gives the same tap timing as a ripple.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      count <= '0;
    end else if (chain.chain_clear) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign chain.count = count;

  // overflow every 1024
  // High in the last cycle before the readable counter rolls to zero.
  assign chain.overflow_evt = &count[OVERFLOW_TAP:0];

endmodule : core_divider

// *** watchdog_unit.sv ***
`timescale 1ns/10ps
module watchdog_unit #(
  parameter bit WATCHDOG_ENABLE = 1'b1
) (
  input wire logic  CLK,
  input wire logic  RSTN,
  chain_if.watchdog chain
);
  import core_timer_pkg::*;

  logic [WATCHDOG_BITS-1:0] wdog;

  function automatic logic tap_wrap(input logic [CHAIN_BITS-1:0] c, input logic [1:0] sel);
    case (sel)
      2'h0:    tap_wrap = &c[PERIODIC_TAP:0];
      2'h1:    tap_wrap = &c[PERIODIC_TAP+1:0];
      2'h2:    tap_wrap = &c[PERIODIC_TAP+2:0];
      default: tap_wrap = &c[PERIODIC_TAP+3:0];
    endcase
  endfunction : tap_wrap

  assign chain.periodic_evt = tap_wrap(chain.count, chain.rate_sel);

  // clear final three stages only
  // The clear touches only these three stages, so the first timeout after
  // a clear lands between seven and eight periodic intervals later.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wdog <= '0;
    end else if (chain.chain_clear || chain.wdog_clear) begin
      wdog <= '0;
    end else if (chain.periodic_evt) begin
      wdog <= wdog + 1'b1;
    end
  end

  assign chain.wdog_timeout = WATCHDOG_ENABLE && chain.periodic_evt && (&wdog);

endmodule : watchdog_unit

// *** core_ripple_timer_chain.sv ***
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module core_ripple_timer_chain #(
  parameter bit WATCHDOG_ENABLE = 1'b1
) (
  input  wire logic                                 CLK,
  input  wire logic                                 RSTN,
  input  wire logic                                 EXT_RESET_N,
  input  wire logic [core_timer_pkg::ADDR_BITS-1:0] ADDRESS,
  input  wire logic                                 READ,
  input  wire logic                                 WRITE,
  input  wire logic [core_timer_pkg::DATA_BITS-1:0] WRITEDATA,
  input  wire logic [3:0]                           BYTEENABLE,
  output logic      [core_timer_pkg::DATA_BITS-1:0] READDATA,
  output logic                                      WAITREQUEST,
  output logic                                      TIMER_IRQ,
  output logic                                      DEVICE_RESET
);
  import core_timer_pkg::*;

  chain_if chain ();

  reset_state_type  reset_state;
  logic             ack;
  logic             wr_take;
  logic             lane0;
  logic [7:0]       wbyte;
  logic             por_end;
  logic             internal_reset;
  logic             overflow_flag;
  logic             periodic_flag;
  logic             overflow_irq_enable;
  logic             periodic_irq_enable;
  logic [1:0]       rate_sel;
  logic [7:0]       status_byte;
  logic [DATA_BITS-1:0] next_readdata;

  core_divider u_divider (
    .CLK   (CLK),
    .RSTN  (RSTN),
    .chain (chain.divider)
  );

  watchdog_unit #(
    .WATCHDOG_ENABLE (WATCHDOG_ENABLE)
  ) u_watchdog (
    .CLK   (CLK),
    .RSTN  (RSTN),
    .chain (chain.watchdog)
  );

  // Bus slave: one wait cycle on every access, so read data come from a flop.
  assign WAITREQUEST = (READ || WRITE) && !ack;
  assign wr_take     = WRITE && ack;
  assign lane0       = BYTEENABLE[0];
  assign wbyte       = WRITEDATA[7:0];

  // Decodes a completed write through byte lane 0 to one register index.
  function automatic logic write_hits(input logic                 take,
                                      input logic                 lane,
                                      input logic [ADDR_BITS-1:0] addr,
                                      input logic [ADDR_BITS-1:0] idx);
    write_hits = take && lane && (addr == idx);
  endfunction : write_hits

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack <= 1'b0;
    end else begin
      ack <= (READ || WRITE) && !ack;
    end
  end

  assign por_end = (reset_state == POWER_ON_DELAY) &&
                   (chain.count[POR_BITS-1:0] == POR_CYCLES - 12'h001);

  // power-on sequence
  // The first state is entered by the asynchronous reset; it leaves once.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      reset_state <= POWER_ON_DELAY;
    end else begin
      case (reset_state)
        POWER_ON_DELAY: begin
          if (por_end) begin
            reset_state <= RUNNING;
          end
        end
        RUNNING: begin
          reset_state <= RUNNING;
        end
        default: begin
          reset_state <= POWER_ON_DELAY;
        end
      endcase
    end
  end

  // watchdog reset
  // External reset is ignored during the power-on delay so the delay
  // always completes; afterwards it or a watchdog timeout resets the device.
  assign internal_reset = (reset_state == RUNNING) &&
                          (!EXT_RESET_N || chain.wdog_timeout);

  assign chain.chain_clear = por_end || internal_reset;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DEVICE_RESET <= 1'b1;
    end else begin
      DEVICE_RESET <= (reset_state == POWER_ON_DELAY && !por_end) || internal_reset;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rate_sel            <= RATE_SEL_RESET;
      overflow_irq_enable <= 1'b0;
      periodic_irq_enable <= 1'b0;
    end else if (internal_reset) begin
      rate_sel            <= RATE_SEL_RESET;
      overflow_irq_enable <= 1'b0;
      periodic_irq_enable <= 1'b0;
    end else if (write_hits(wr_take, lane0, ADDRESS, IDX_CONTROL_STATUS)) begin
      rate_sel            <= {wbyte[BIT_RATE_SEL_HI], wbyte[BIT_RATE_SEL_LO]};
      overflow_irq_enable <= wbyte[BIT_OVERFLOW_IRQ_ENABLE];
      periodic_irq_enable <= wbyte[BIT_PERIODIC_IRQ_ENABLE];
    end
  end

  assign chain.rate_sel = rate_sel;

  assign chain.wdog_clear = write_hits(wr_take, lane0, ADDRESS, IDX_WATCHDOG_CLEAR) &&
                            !wbyte[BIT_WATCHDOG_CLEAR];

  // overflow flag clear
  // A wrap in the same cycle as the clear keeps the flag set.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      overflow_flag <= 1'b0;
    end else if (internal_reset) begin
      overflow_flag <= 1'b0;
    end else if (chain.overflow_evt) begin
      overflow_flag <= 1'b1;
    end else if (write_hits(wr_take, lane0, ADDRESS, IDX_CONTROL_STATUS) &&
                 wbyte[BIT_OVERFLOW_FLAG_CLEAR]) begin
      overflow_flag <= 1'b0;
    end
  end

  // Periodic flag follows the same set-over-clear discipline.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      periodic_flag <= 1'b0;
    end else if (internal_reset) begin
      periodic_flag <= 1'b0;
    end else if (chain.periodic_evt) begin
      periodic_flag <= 1'b1;
    end else if (write_hits(wr_take, lane0, ADDRESS, IDX_CONTROL_STATUS) &&
                 wbyte[BIT_PERIODIC_FLAG_CLEAR]) begin
      periodic_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= (overflow_flag && overflow_irq_enable) ||
                   (periodic_flag && periodic_irq_enable);
    end
  end

  always_comb begin
    status_byte                          = 8'h00;
    status_byte[BIT_OVERFLOW_FLAG]       = overflow_flag;
    status_byte[BIT_PERIODIC_FLAG]       = periodic_flag;
    status_byte[BIT_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable;
    status_byte[BIT_PERIODIC_IRQ_ENABLE] = periodic_irq_enable;
    status_byte[BIT_RATE_SEL_HI]         = rate_sel[1];
    status_byte[BIT_RATE_SEL_LO]         = rate_sel[0];
  end

  always_comb begin
    next_readdata = '0;
    case (ADDRESS)
      IDX_CONTROL_STATUS: next_readdata[7:0] = status_byte;
      IDX_CHAIN_COUNT:    next_readdata[7:0] = chain.count[PRESCALE_BITS+COUNT_BITS-1:PRESCALE_BITS];
      default:            next_readdata = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      READDATA <= '0;
    end else if (READ && !ack) begin
      READDATA <= next_readdata;
    end
  end

endmodule : core_ripple_timer_chain

// *** core_ripple_timer_chain_props.sv ***
`timescale 1ns/10ps
module timer_chain_props
  import core_timer_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 RSTN,
  input wire logic                 EXT_RESET_N,
  input wire logic [ADDR_BITS-1:0] ADDRESS,
  input wire logic                 READ,
  input wire logic                 WRITE,
  input wire logic [DATA_BITS-1:0] WRITEDATA,
  input wire logic [3:0]           BYTEENABLE,
  input wire logic [DATA_BITS-1:0] READDATA,
  input wire logic                 WAITREQUEST,
  input wire logic                 TIMER_IRQ,
  input wire logic                 DEVICE_RESET
);
  logic [12:0] por_cnt;
  logic        por_done;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // The helper stops counting once the power-on delay has ended.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      por_cnt  <= 13'h0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt  <= por_cnt + 13'h1;
      por_done <= !DEVICE_RESET;
    end
  end
  sequence s_taken;
    (READ || WRITE) && WAITREQUEST;
  endsequence
  sequence s_ext_cause;
    por_done && !EXT_RESET_N;
  endsequence
  a_wait_one: assert property (s_taken |=> !WAITREQUEST)
    else $error("access not answered after one wait cycle");
  a_idle_no_wait: assert property (!(READ || WRITE) |-> !WAITREQUEST)
    else $error("wait raised while idle");
  a_read_stable: assert property (!(READ && WAITREQUEST) |=> $stable(READDATA))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (READ && WAITREQUEST && ADDRESS != IDX_CONTROL_STATUS
    && ADDRESS != IDX_CHAIN_COUNT |=> READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_por_active: assert property ($rose(RSTN) |-> DEVICE_RESET [*8])
    else $error("device reset not held after power-on");
  a_por_length: assert property (!por_done && $fell(DEVICE_RESET)
    |-> por_cnt == 13'd4064)
    else $error("power-on delay length wrong");
  a_ext_dev_reset: assert property (s_ext_cause |-> ##[1:2] DEVICE_RESET)
    else $error("external reset gave no device reset");
  a_ext_irq_off: assert property (s_ext_cause |=> ##[1:2] !TIMER_IRQ)
    else $error("interrupt survived external reset");
  a_enable_off: assert property (WRITE && !WAITREQUEST && ADDRESS == IDX_CONTROL_STATUS
    && BYTEENABLE[0] && WRITEDATA[5:4] == 2'h0 |=> ##1 !TIMER_IRQ)
    else $error("interrupt raised with enables clear");
endmodule : timer_chain_props
bind core_ripple_timer_chain timer_chain_props timer_chain_props_inst (.CLK(CLK), .RSTN(RSTN),
  .EXT_RESET_N(EXT_RESET_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .TIMER_IRQ(TIMER_IRQ), .DEVICE_RESET(DEVICE_RESET));

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  import core_timer_pkg::*;
  logic                 CLK, RSTN, EXT_RESET_N, READ, WRITE;
  logic                 WAITREQUEST, TIMER_IRQ, DEVICE_RESET;
  logic [ADDR_BITS-1:0] ADDRESS;
  logic [DATA_BITS-1:0] WRITEDATA, READDATA, rd;
  logic [3:0]           BYTEENABLE;
  int                   num_errors, check_count, cyc, t0, t1;
  core_ripple_timer_chain core_ripple_timer_chain_inst (.CLK(CLK), .RSTN(RSTN),
    .EXT_RESET_N(EXT_RESET_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .TIMER_IRQ(TIMER_IRQ), .DEVICE_RESET(DEVICE_RESET));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // The full run needs about 70000 cycles, so 80000 leaves margin.
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(logic wr, logic [12:0] a, logic [7:0] d);
    @(posedge CLK);
    READ      <= !wr;
    WRITE     <= wr;
    ADDRESS   <= a;
    WRITEDATA <= {24'h0, d};
    do @(posedge CLK); while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    READ  <= 1'b0;
    WRITE <= 1'b0;
  endtask : bus
  // Leaves t1 at the cycle in which the interrupt was first seen high.
  task automatic wait_irq(int limit);
    int start;
    start = cyc;
    while (TIMER_IRQ !== 1'b1 && cyc - start < limit) @(negedge CLK);
    t1 = cyc;
  endtask : wait_irq
  task automatic t_reset(int rel);
    bus(1'b0, IDX_CONTROL_STATUS, 8'h0);
    check("status after reset", rd, 32'h03);
    bus(1'b1, 13'h0020, 8'hff);
    bus(1'b0, 13'h0020, 8'h0);
    check("unmapped", rd, 32'h0);
    check("delay active", DEVICE_RESET, 1'b1);
    while (DEVICE_RESET !== 1'b0 && cyc - rel < 5000) @(negedge CLK);
    check("delay length", cyc - rel, 32'd4064);
    $display("reset test done");
  endtask : t_reset
  task automatic t_count();
    logic [7:0] first;
    bus(1'b0, IDX_CHAIN_COUNT, 8'h0);
    first = rd[7:0];
    check("count from zero", first, 32'h0);
    repeat (61) @(posedge CLK);
    bus(1'b0, IDX_CHAIN_COUNT, 8'h0);
    check("count step", 8'(rd[7:0] - first), 32'h10);
    first = rd[7:0];
    repeat (61) @(posedge CLK);
    bus(1'b0, IDX_CHAIN_COUNT, 8'h0);
    check("count undisturbed", 8'(rd[7:0] - first), 32'h10);
    $display("count test done");
  endtask : t_count
  task automatic t_overflow();
    int first;
    bus(1'b1, IDX_CONTROL_STATUS, 8'h2b);
    wait_irq(2000);
    first = t1;
    bus(1'b1, IDX_CONTROL_STATUS, 8'h2b);
    repeat (2) @(negedge CLK);
    check("irq after clear", TIMER_IRQ, 1'b0);
    wait_irq(2000);
    check("overflow period", t1 - first, 32'd1024);
    bus(1'b0, IDX_CONTROL_STATUS, 8'h0);
    check("status flag set", rd, 32'ha3);
    bus(1'b1, IDX_CONTROL_STATUS, 8'h03);
    bus(1'b0, IDX_CONTROL_STATUS, 8'h0);
    check("zero clear kept", rd, 32'h83);
    check("irq disabled", TIMER_IRQ, 1'b0);
    $display("overflow test done");
  endtask : t_overflow
  task automatic t_periodic();
    int first;
    bus(1'b1, IDX_CONTROL_STATUS, 8'h14);
    wait_irq(17000);
    first = t1;
    bus(1'b1, IDX_CONTROL_STATUS, 8'h14);
    // The request stays high one cycle after the clear lands.
    repeat (2) @(negedge CLK);
    wait_irq(17000);
    check("periodic period", t1 - first, 32'd16384);
    $display("periodic test done");
  endtask : t_periodic
  task automatic t_ext();
    bus(1'b1, IDX_WATCHDOG_CLEAR, 8'h0);
    bus(1'b0, IDX_WATCHDOG_CLEAR, 8'h0);
    check("watchdog clear read", rd, 32'h0);
    EXT_RESET_N <= 1'b0;
    repeat (3) @(posedge CLK);
    EXT_RESET_N <= 1'b1;
    // The last clear of the chain happens at this edge; t0 marks it.
    @(negedge CLK);
    t0 = cyc;
    bus(1'b0, IDX_CHAIN_COUNT, 8'h0);
    check("count after ext", rd, 32'h0);
    bus(1'b0, IDX_CONTROL_STATUS, 8'h0);
    check("status after ext", rd, 32'h03);
    $display("external reset test done");
  endtask : t_ext
  // Rate code one wraps every 2^15 cycles; the request follows one cycle later.
  task automatic t_rate();
    bus(1'b1, IDX_CONTROL_STATUS, 8'h15);
    wait_irq(34000);
    check("rate one period", t1 - t0, 32'd32769);
    bus(1'b0, IDX_CONTROL_STATUS, 8'h0);
    check("status rate one", rd, 32'hd1);
    $display("rate test done");
  endtask : t_rate
  initial begin
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    RSTN = 1'b0;
    EXT_RESET_N = 1'b1;
    READ = 1'b0;
    WRITE = 1'b0;
    ADDRESS = '0;
    WRITEDATA = '0;
    BYTEENABLE = 4'hf;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    @(negedge CLK);
    t_reset(cyc);
    t_count();
    t_overflow();
    t_periodic();
    t_ext();
    t_rate();
    end_sim();
  end
endmodule : tb
